/* src/spsel_top.v */
// Serial port selection and SPI slave output path
`include "spsel_regs.vh"
`default_nettype none
module spsel_top #(
    parameter FRAME_MAX = 16
) (
    input wire clk,
    input wire reset_n,
    input wire variant_smt,
    input wire uart_tx_strap_n,
    input wire uart_cfg_strap_n,
    input wire [`SPSEL_PIN_CFG_W-1:0] stored_uart_tx_pin_cfg,
    input wire [`SPSEL_PIN_CFG_W-1:0] stored_spi_pin_cfg,
    input wire [`SPSEL_PIN_CFG_W-1:0] stored_smt_attention_pin_cfg,
    input wire [`SPSEL_PIN_CFG_W-1:0] stored_th_attention_pin_cfg,
    input wire cfg_write,
    input wire uart_rx_seen,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    input wire tx_last,
    input wire spi_sclk,
    input wire spi_ss_n,
    input wire spi_mosi,
    output reg tx_ready,
    output reg uart_out_valid,
    output reg [7:0] uart_out_byte,
    output reg [7:0] rx_out_byte,
    output reg rx_out_valid,
    output reg spi_miso_o,
    output reg spi_miso_oe,
    output reg attention_out,
    output reg [1:0] port_sel,
    output reg uart_enable,
    output reg uart_command_mode,
    output reg [16:0] uart_baud,
    output reg [`SPSEL_PIN_CFG_W-1:0] uart_tx_pin_cfg,
    output reg [`SPSEL_PIN_CFG_W-1:0] spi_pin_cfg,
    output reg [`SPSEL_PIN_CFG_W-1:0] th_attention_pin_cfg,
    output reg [`SPSEL_PIN_CFG_W-1:0] smt_attention_pin_cfg,
    output reg nv_write,
    output reg [`SPSEL_PIN_CFG_W-1:0] nv_uart_tx_pin_cfg,
    output reg [`SPSEL_PIN_CFG_W-1:0] nv_spi_pin_cfg
);
    localparam ST_BOOT = 4'b0001;
    localparam ST_UART = 4'b0010;
    localparam ST_DUAL = 4'b0100;
    localparam ST_SPI = 4'b1000;
    localparam FR_IDLE = 5'b00001;
    localparam FR_LEN = 5'b00010;
    localparam FR_LENL = 5'b00100;
    localparam FR_DATA = 5'b01000;
    localparam FR_SUM = 5'b10000;

    wire sclk_s;
    wire ss_n_s;
    wire mosi_s;
    wire tx_strap_s;
    wire cfg_strap_s;
    reg sclk_q;
    reg ss_n_q;
    reg [3:0] st_q;
    reg [4:0] fr_q;
    reg [7:0] buf_q [0:FRAME_MAX-1];
    reg [7:0] len_q;
    reg [7:0] rd_q;
    reg [7:0] sum_q;
    reg full_q;
    reg status_pend_q;
    reg [1:0] st_idx_q;
    reg [1:0] boot_cnt_q;
    reg [7:0] ld_byte;
    reg ld_valid;
    wire ld_take;
    wire [7:0] sh_rx;
    wire sh_rx_valid;
    wire sh_miso;
    wire ss_active;
    wire ss_rise;
    wire sclk_rise;
    wire sclk_fall;

    // Every pin from the master passes two flops before use
    spsel_sync #(.RESET_VAL(1'b0)) u_sclk (.clk(clk), .reset_n(reset_n),
        .async_in(spi_sclk), .sync_out(sclk_s));
    spsel_sync #(.RESET_VAL(1'b1)) u_ss (.clk(clk), .reset_n(reset_n),
        .async_in(spi_ss_n), .sync_out(ss_n_s));
    spsel_sync #(.RESET_VAL(1'b0)) u_mosi (.clk(clk), .reset_n(reset_n),
        .async_in(spi_mosi), .sync_out(mosi_s));
    spsel_sync #(.RESET_VAL(1'b1)) u_txs (.clk(clk), .reset_n(reset_n),
        .async_in(uart_tx_strap_n), .sync_out(tx_strap_s));
    spsel_sync #(.RESET_VAL(1'b1)) u_cfs (.clk(clk), .reset_n(reset_n),
        .async_in(uart_cfg_strap_n), .sync_out(cfg_strap_s));

    // Edge history of the synchronised link signals
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_q <= 1'b0;
            ss_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            ss_n_q <= ss_n_s;
        end
    end

    assign ss_active = !ss_n_s;
    assign ss_rise = ss_n_s && !ss_n_q;
    assign sclk_rise = sclk_s && !sclk_q;
    assign sclk_fall = !sclk_s && sclk_q;

    spsel_shift u_shift (
        .clk(clk),
        .reset_n(reset_n),
        .active(ss_active),
        .rise(sclk_rise),
        .fall(sclk_fall),
        .mosi(mosi_s),
        .load_valid(ld_valid),
        .load_byte(ld_byte),
        .load_take(ld_take),
        .rx_byte(sh_rx),
        .rx_valid(sh_rx_valid),
        .miso_bit(sh_miso)
    );

    function pin_on;
        input [`SPSEL_PIN_CFG_W-1:0] cfg;
        begin
            pin_on = (cfg == `SPSEL_PIN_CFG_PERIPH);
        end
    endfunction

    // Port selection: straps are read after reset release, once
    // Strap sampling waits two cycles for the synchronisers to fill.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_BOOT;
            boot_cnt_q <= 2'h0;
            status_pend_q <= 1'b0;
            port_sel <= `SPSEL_PORT_UART;
            uart_enable <= 1'b1;
            uart_command_mode <= 1'b0;
            uart_baud <= `SPSEL_UART_BAUD_DEFAULT;
            uart_tx_pin_cfg <= `SPSEL_PIN_CFG_PERIPH;
            spi_pin_cfg <= `SPSEL_PIN_CFG_DISABLED;
            th_attention_pin_cfg <= `SPSEL_PIN_CFG_DISABLED;
            smt_attention_pin_cfg <= `SPSEL_PIN_CFG_DISABLED;
            nv_write <= 1'b0;
            nv_uart_tx_pin_cfg <= `SPSEL_PIN_CFG_DISABLED;
            nv_spi_pin_cfg <= `SPSEL_PIN_CFG_DISABLED;
        end else begin
            nv_write <= 1'b0;
            case (st_q)
                ST_BOOT: begin
                    // Volatile copies start from the stored values
                    uart_tx_pin_cfg <= stored_uart_tx_pin_cfg;
                    spi_pin_cfg <= stored_spi_pin_cfg;
                    th_attention_pin_cfg <= stored_th_attention_pin_cfg;
                    smt_attention_pin_cfg <= stored_smt_attention_pin_cfg;
                    boot_cnt_q <= boot_cnt_q + 2'h1;
                    if (boot_cnt_q != 2'h2) begin
                        st_q <= ST_BOOT;
                    end else if (!cfg_strap_s) begin
                        uart_tx_pin_cfg <= `SPSEL_PIN_CFG_PERIPH;
                        uart_baud <= `SPSEL_UART_BAUD_DEFAULT;
                        uart_command_mode <= 1'b1;
                        st_q <= ST_UART;
                    end else if (!tx_strap_s && !variant_smt) begin
                        uart_tx_pin_cfg <= `SPSEL_PIN_CFG_DISABLED;
                        spi_pin_cfg <= `SPSEL_PIN_CFG_PERIPH;
                        th_attention_pin_cfg <= `SPSEL_PIN_CFG_PERIPH;
                        smt_attention_pin_cfg <= `SPSEL_PIN_CFG_PERIPH;
                        status_pend_q <= 1'b1;
                        st_q <= ST_SPI;
                    end else if (pin_on(stored_spi_pin_cfg) &&
                                 !pin_on(stored_uart_tx_pin_cfg)) begin
                        status_pend_q <= 1'b1;
                        st_q <= ST_SPI;
                    end else if (pin_on(stored_spi_pin_cfg)) begin
                        st_q <= ST_DUAL;
                    end else begin
                        st_q <= ST_UART;
                    end
                end
                ST_DUAL: begin
                    // First SPI input (slave select low) claims the port
                    if (ss_active) begin
                        st_q <= ST_SPI;
                    end else if (uart_rx_seen) begin
                        st_q <= ST_UART;
                    end
                end
                ST_UART: begin
                    st_q <= ST_UART;
                end
                ST_SPI: begin
                    st_q <= ST_SPI;
                    if (status_pend_q && ld_take && st_idx_q == 2'h3) begin
                        status_pend_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_BOOT;
                end
            endcase
            if (st_q == ST_SPI) begin
                port_sel <= `SPSEL_PORT_SPI;
                uart_enable <= 1'b0;
            end else begin
                port_sel <= `SPSEL_PORT_UART;
                uart_enable <= 1'b1;
            end
            // Write persists the live settings, or UART TX disabled and SPI peripheral while SPI is selected
            if (cfg_write && st_q != ST_BOOT) begin
                nv_write <= 1'b1;
                nv_uart_tx_pin_cfg <= (st_q == ST_SPI) ?
                    `SPSEL_PIN_CFG_DISABLED : uart_tx_pin_cfg;
                nv_spi_pin_cfg <= (st_q == ST_SPI) ?
                    `SPSEL_PIN_CFG_PERIPH : spi_pin_cfg;
            end
        end
    end

    wire spi_sel = (st_q == ST_SPI);
    wire fr_accept = (fr_q == FR_IDLE) && !full_q && tx_valid &&
                     !(spi_sel && status_pend_q);

    // Payload capture; a frame holds at most FRAME_MAX bytes
    always @(posedge clk) begin
        if (fr_accept || (tx_valid && tx_ready && !full_q)) begin
            buf_q[len_q[3:0]] <= tx_byte;
        end
    end

    // Frame builder: start byte, length, payload, checksum, never escaped
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fr_q <= FR_IDLE;
            len_q <= 8'h00;
            rd_q <= 8'h00;
            sum_q <= 8'h00;
            full_q <= 1'b0;
            st_idx_q <= 2'h0;
            tx_ready <= 1'b0;
            uart_out_valid <= 1'b0;
            uart_out_byte <= 8'h00;
            rx_out_byte <= 8'h00;
            rx_out_valid <= 1'b0;
        end else begin
            uart_out_valid <= 1'b0;
            rx_out_valid <= sh_rx_valid && spi_sel && ss_active;
            if (sh_rx_valid) begin
                rx_out_byte <= sh_rx;
            end
            tx_ready <= !full_q && (fr_q == FR_IDLE) && (st_q != ST_BOOT) &&
                        !(spi_sel && status_pend_q);
            if (!full_q) begin
                if (tx_valid && tx_ready) begin
                    len_q <= len_q + 8'h01;
                    if (tx_last || len_q == FRAME_MAX - 1) begin
                        full_q <= 1'b1;
                        tx_ready <= 1'b0;
                    end
                end
            end else if (!spi_sel) begin
                // UART side: pass bytes through raw, one per cycle
                uart_out_valid <= 1'b1;
                uart_out_byte <= buf_q[rd_q[3:0]];
                rd_q <= rd_q + 8'h01;
                if (rd_q + 8'h01 == len_q) begin
                    full_q <= 1'b0;
                    len_q <= 8'h00;
                    rd_q <= 8'h00;
                end
            end else if (ld_take) begin
                case (fr_q)
                    FR_IDLE: fr_q <= FR_LEN;
                    FR_LEN: fr_q <= FR_LENL;
                    FR_LENL: begin
                        fr_q <= FR_DATA;
                        sum_q <= 8'h00;
                    end
                    FR_DATA: begin
                        sum_q <= sum_q + buf_q[rd_q[3:0]];
                        rd_q <= rd_q + 8'h01;
                        if (rd_q + 8'h01 == len_q) begin
                            fr_q <= FR_SUM;
                        end
                    end
                    FR_SUM: begin
                        fr_q <= FR_IDLE;
                        full_q <= 1'b0;
                        len_q <= 8'h00;
                        rd_q <= 8'h00;
                    end
                    default: fr_q <= FR_IDLE;
                endcase
            end
            // Modem status frame byte walk: 7e 00 02 8a, no status byte or checksum
            if (spi_sel && status_pend_q && ld_take) begin
                st_idx_q <= st_idx_q + 2'h1;
            end
        end
    end

    // Byte offered to the shifter: API mode 1 framing only
    always @* begin
        ld_valid = 1'b0;
        ld_byte = `SPSEL_API_START;
        if (spi_sel && status_pend_q) begin
            ld_valid = 1'b1;
            case (st_idx_q)
                2'h0: ld_byte = `SPSEL_API_START;
                2'h1: ld_byte = 8'h00;
                2'h2: ld_byte = 8'h02;
                default: ld_byte = `SPSEL_MODEM_STATUS_TYPE;
            endcase
        end else if (spi_sel && full_q) begin
            ld_valid = 1'b1;
            case (fr_q)
                FR_IDLE: ld_byte = `SPSEL_API_START;
                FR_LEN: ld_byte = 8'h00;
                FR_LENL: ld_byte = len_q;
                FR_DATA: ld_byte = buf_q[rd_q[3:0]];
                FR_SUM: ld_byte = 8'hff - sum_q;
                default: ld_byte = `SPSEL_API_START;
            endcase
        end
    end

    // MISO drive and attention follow slave select and queued data
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spi_miso_o <= 1'b0;
            spi_miso_oe <= 1'b0;
            attention_out <= 1'b0;
        end else begin
            spi_miso_o <= sh_miso;
            spi_miso_oe <= spi_sel && ss_active && !ss_rise;
            // Pulled high regardless of attention pin config (optional pin)
            attention_out <= spi_sel && (status_pend_q || full_q);
        end
    end
endmodule
`default_nettype wire

/* src/spsel_regs.vh */
// Constants for the serial port selection and SPI slave block
`ifndef SPSEL_REGS_VH
`define SPSEL_REGS_VH
`define SPSEL_PIN_CFG_W 4
`define SPSEL_PIN_CFG_PERIPH 4'h1
`define SPSEL_PIN_CFG_DISABLED 4'h0
`define SPSEL_API_START 8'h7e
`define SPSEL_MODEM_STATUS_TYPE 8'h8a
`define SPSEL_MODEM_STATUS_SPI 8'h00
`define SPSEL_UART_BAUD_DEFAULT 17'h02580
`define SPSEL_PORT_UART 2'h1
`define SPSEL_PORT_SPI 2'h2
`endif

/* src/spsel_sync.v */
// Two-flop synchroniser for a single asynchronous level
`default_nettype none
module spsel_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire reset_n,
    input wire async_in,
    output reg sync_out
);
    reg meta_q;

    // First stage feeds only the second stage
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* src/spsel_shift.v */
// SPI mode 0 byte shifter driven by sampled clock edges, MSB first
`default_nettype none
module spsel_shift (
    input wire clk,
    input wire reset_n,
    input wire active,
    input wire rise,
    input wire fall,
    input wire mosi,
    input wire load_valid,
    input wire [7:0] load_byte,
    output reg load_take,
    output reg [7:0] rx_byte,
    output reg rx_valid,
    output reg miso_bit
);
    reg [7:0] tx_q;
    reg [7:0] rx_q;
    reg [2:0] cnt_q;
    reg have_q;

    // Sample on rising clock, shift on falling clock (CPOL 0, CPHA 0)
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            cnt_q <= 3'h0;
            have_q <= 1'b0;
            load_take <= 1'b0;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            miso_bit <= 1'b0;
        end else begin
            load_take <= 1'b0;
            rx_valid <= 1'b0;
            if (!active) begin
                cnt_q <= 3'h0;
                // Preload next byte so bit 7 is ready before the first edge
                if (!have_q && load_valid) begin
                    tx_q <= load_byte;
                    miso_bit <= load_byte[7];
                    have_q <= 1'b1;
                    load_take <= 1'b1;
                end
            end else if (rise) begin
                rx_q <= {rx_q[6:0], mosi};
                cnt_q <= cnt_q + 3'h1;
                if (cnt_q == 3'h7) begin
                    rx_byte <= {rx_q[6:0], mosi};
                    rx_valid <= 1'b1;
                    have_q <= 1'b0;
                end
            end else if (fall) begin
                if (cnt_q == 3'h0) begin
                    // Byte boundary: fresh byte, or repeat last bit when empty
                    if (load_valid) begin
                        tx_q <= load_byte;
                        miso_bit <= load_byte[7];
                        have_q <= 1'b1;
                        load_take <= 1'b1;
                    end
                end else if (have_q) begin
                    tx_q <= {tx_q[6:0], 1'b0};
                    miso_bit <= tx_q[6];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* dv/spsel_checker.sv */
// Concurrent checks on the port selection and SPI slave top
`include "spsel_regs.vh"
`default_nettype none
module spsel_checker (
    input wire clk,
    input wire reset_n,
    input wire spi_ss_n,
    input wire cfg_write,
    input wire [1:0] port_sel,
    input wire spi_miso_oe,
    input wire attention_out,
    input wire uart_enable,
    input wire uart_command_mode,
    input wire [16:0] uart_baud,
    input wire [3:0] spi_pin_cfg,
    input wire uart_out_valid,
    input wire nv_write,
    input wire [3:0] nv_spi_pin_cfg
);
    timeunit 1ns;
    timeprecision 100ps;
    // One clock domain, so clocking and reset are shared by every property
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // MISO drive may only start once the synchronised select has been low
    a_oe_after_sel: assert property ($rose(spi_miso_oe) |-> !$past(spi_ss_n, 2))
        else $error("miso driven without slave select");
    a_oe_with_sel: assert property ((port_sel == `SPSEL_PORT_SPI && !spi_ss_n)[*6] |=> spi_miso_oe)
        else $error("miso not driven while selected");
    a_oe_release: assert property ($rose(spi_ss_n) |-> ##[1:5] !spi_miso_oe)
        else $error("miso not released after select rise");
    a_oe_idle: assert property (spi_ss_n [*6] |=> !spi_miso_oe)
        else $error("miso driven while deselected");
    a_port_sticks: assert property (port_sel == `SPSEL_PORT_SPI |=> port_sel == `SPSEL_PORT_SPI)
        else $error("port left spi without reset");
    a_spi_no_uart: assert property ((port_sel == `SPSEL_PORT_SPI)[*4] |-> !uart_enable)
        else $error("uart still enabled in spi mode");
    a_spi_pins: assert property ((port_sel == `SPSEL_PORT_SPI)[*4] |-> spi_pin_cfg == 4'h1)
        else $error("spi pins not peripheral in spi mode");
    a_uart_route: assert property (uart_out_valid |-> port_sel == `SPSEL_PORT_UART)
        else $error("uart output while spi selected");
    a_atten_spi: assert property ($rose(attention_out) |-> port_sel == `SPSEL_PORT_SPI)
        else $error("attention raised outside spi mode");
    a_atten_drain: assert property ($fell(attention_out) |-> !$past(spi_ss_n))
        else $error("attention dropped with no master access");
    a_nv_store: assert property (cfg_write && port_sel == `SPSEL_PORT_SPI
        |-> ##[0:3] nv_write && nv_spi_pin_cfg == 4'h1)
        else $error("config write did not store spi pins");
    a_recover_baud: assert property (uart_command_mode
        |-> uart_baud == 17'h02580 && port_sel == `SPSEL_PORT_UART)
        else $error("command mode without default uart");

    // Main scenarios seen at least once
    c_atten_drop: cover property ($fell(attention_out));
    c_release: cover property ($rose(spi_ss_n) ##1 spi_miso_oe);
    c_nv_spi: cover property (nv_write && port_sel == `SPSEL_PORT_SPI);
endmodule

bind spsel_top spsel_checker spsel_checker_i (.clk, .reset_n, .spi_ss_n, .cfg_write,
    .port_sel, .spi_miso_oe, .attention_out, .uart_enable, .uart_command_mode, .uart_baud,
    .spi_pin_cfg, .uart_out_valid, .nv_write, .nv_spi_pin_cfg);
`default_nettype wire

/* dv/spsel_host.sv */
// SPI master host model: mode 0, MSB first, hunts frames on MISO
`default_nettype none
module spsel_host (
    output var logic sclk,
    output var logic ss_n,
    output var logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // A released MISO shows the inverse level, so a stale bit never passes
    wire logic miso_line = miso_oe ? miso_o : ~miso_o;

    // Clock idles low and stands still outside transfers
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    // Select or release; a released MOSI flips rather than holding data
    task automatic select(input bit on);
        ss_n = !on;
        if (!on) mosi = ~mosi;
        #100;
    endtask

    // One byte each way: MOSI set while SCLK low, MISO sampled on the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #62.5 sclk = 1'b1;
            rx[i] = miso_line;
            #62.5 sclk = 1'b0;
        end
    endtask

    // Bytes ahead of a start delimiter carry nothing and are dropped
    task automatic hunt(output bit ok);
        logic [7:0] b;
        ok = 1'b0;
        for (int i = 0; i < 12 && !ok; i++) begin
            xfer(8'h00, b);
            ok = (b === 8'h7e);
        end
    endtask
endmodule
`default_nettype wire

/* dv/tb_spi_port_select_slave.sv */
// Self-checking bench for port selection and the SPI slave path
`include "spsel_regs.vh"
`default_nettype none
module tb_spi_port_select_slave;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, reset_n = 1'b0, variant_smt = 1'b0, uart_tx_strap_n = 1'b1;
    logic uart_cfg_strap_n = 1'b1, cfg_write = 1'b0, uart_rx_seen = 1'b0, tx_valid = 1'b0;
    logic tx_last = 1'b0, tx_ready, uart_out_valid, rx_out_valid, spi_miso_o, spi_miso_oe;
    logic attention_out, uart_enable, uart_command_mode, nv_write;
    logic [3:0] stored_uart_tx_pin_cfg = 4'h1, stored_spi_pin_cfg = 4'h0;
    logic [3:0] stored_smt_attention_pin_cfg = 4'h1, stored_th_attention_pin_cfg = 4'h1;
    logic [3:0] uart_tx_pin_cfg, spi_pin_cfg, th_attention_pin_cfg, smt_attention_pin_cfg;
    logic [3:0] nv_uart_tx_pin_cfg, nv_spi_pin_cfg, nv_u = 4'h0, nv_s = 4'h0;
    logic [7:0] tx_byte = 8'h00, uart_out_byte, rx_out_byte, rx_last = 8'h00;
    logic [7:0] esc[4] = '{8'h7e, 8'h7d, 8'h11, 8'h13};
    logic [1:0] port_sel;
    logic [16:0] uart_baud;
    wire spi_sclk, spi_ss_n, spi_mosi;
    int n_uart = 0;
    int n_mismatch = 0;
    int samples_checked = 0;

    spsel_top spsel_top_i (.clk, .reset_n, .variant_smt, .uart_tx_strap_n, .uart_cfg_strap_n,
        .stored_uart_tx_pin_cfg, .stored_spi_pin_cfg, .stored_smt_attention_pin_cfg,
        .stored_th_attention_pin_cfg, .cfg_write, .uart_rx_seen, .tx_valid, .tx_byte, .tx_last,
        .spi_sclk, .spi_ss_n, .spi_mosi, .tx_ready, .uart_out_valid, .uart_out_byte,
        .rx_out_byte, .rx_out_valid, .spi_miso_o, .spi_miso_oe, .attention_out, .port_sel,
        .uart_enable, .uart_command_mode, .uart_baud, .uart_tx_pin_cfg, .spi_pin_cfg,
        .th_attention_pin_cfg, .smt_attention_pin_cfg, .nv_write, .nv_uart_tx_pin_cfg,
        .nv_spi_pin_cfg);
    spsel_host spsel_host_i (.sclk(spi_sclk), .ss_n(spi_ss_n), .mosi(spi_mosi),
        .miso_o(spi_miso_o), .miso_oe(spi_miso_oe));

    initial begin
        forever #5 clk = ~clk;
    end

    // Keep what the design reports so checks can look back at it later
    always @(posedge clk) begin
        if (rx_out_valid === 1'b1) rx_last <= rx_out_byte;
        if (uart_out_valid === 1'b1) n_uart <= n_uart + 1;
        if (nv_write === 1'b1) nv_u <= nv_uart_tx_pin_cfg;
        if (nv_write === 1'b1) nv_s <= nv_spi_pin_cfg;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A wait that ran out is a mismatch and ends the run
    task automatic bound_hit(input int k, input int lim);
        if (k >= lim) begin
            chk(k, 0);
            close_out();
        end
    endtask

    // Straps are held well past the sample point, longer than the sync needs
    task automatic boot(input bit smt, input bit txs_n, input bit cfgs_n,
        input logic [3:0] su, input logic [3:0] sp);
        @(posedge clk);
        #1 reset_n = 1'b0;
        variant_smt = smt;
        uart_tx_strap_n = txs_n;
        uart_cfg_strap_n = cfgs_n;
        stored_uart_tx_pin_cfg = su;
        stored_spi_pin_cfg = sp;
        repeat (8) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (10) @(posedge clk);
        #1 uart_tx_strap_n = 1'b1;
        uart_cfg_strap_n = 1'b1;
    endtask

    task automatic pulse_cfg();
        @(posedge clk);
        #1 cfg_write = 1'b1;
        @(posedge clk);
        #1 cfg_write = 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Each byte is held until the edge that sees tx_ready high
    task automatic send(input logic [7:0] pl[$]);
        int k;
        @(posedge clk);
        #1;
        foreach (pl[i]) begin
            tx_valid = 1'b1;
            tx_byte = pl[i];
            tx_last = (i == pl.size() - 1);
            for (k = 0; tx_ready !== 1'b1 && k < 500; k++) @(posedge clk) #1;
            bound_hit(k, 500);
            @(posedge clk);
            #1;
        end
        tx_valid = 1'b0;
        tx_last = 1'b0;
    endtask

    task automatic wait_att();
        int k;
        for (k = 0; attention_out !== 1'b1 && k < 100; k++) @(posedge clk);
        bound_hit(k, 100);
    endtask

    // Read one frame off MISO, then the filler that follows its last bit
    task automatic expect_frame(input logic [7:0] pl[$], input int len, input bit with_sum);
        logic [7:0] b, last, sum;
        bit ok;
        sum = 8'h00;
        spsel_host_i.select(1'b1);
        spsel_host_i.hunt(ok);
        chk(ok, 1);
        spsel_host_i.xfer(8'ha5, b);
        chk(b, 8'h00);
        repeat (6) @(posedge clk);
        chk(rx_last, 8'ha5);
        spsel_host_i.xfer(8'h00, b);
        chk(b, len);
        foreach (pl[i]) begin
            spsel_host_i.xfer(8'h00, b);
            chk(b, pl[i]);
            sum = sum + pl[i];
        end
        last = with_sum ? 8'hff - sum : pl[pl.size() - 1];
        if (with_sum) begin
            spsel_host_i.xfer(8'h00, b);
            chk(b, last);
        end
        spsel_host_i.xfer(8'h00, b);
        chk(b, {8{last[0]}});
        chk(attention_out, 0);
        spsel_host_i.select(1'b0);
        chk(spi_miso_oe, 0);
    endtask

    // Corner frame is full length and carries every byte that would need escaping
    task automatic payload_round(input bit corner);
        logic [7:0] pl[$];
        int n;
        n = corner ? 16 : 1 + $urandom_range(3);
        for (int i = 0; i < n; i++) pl.push_back(corner && i < 4 ? esc[i] : 8'($urandom));
        send(pl);
        wait_att();
        expect_frame(pl, n, 1'b1);
    endtask

    initial begin
        void'($urandom(32'h2795));
        // Forcing must override any stored attention setting
        stored_th_attention_pin_cfg = 4'($urandom);
        stored_smt_attention_pin_cfg = 4'($urandom);
        boot(1'b0, 1'b0, 1'b1, 4'h1, 4'h0);
        wait_att();
        chk(port_sel, `SPSEL_PORT_SPI);
        chk(uart_enable, 0);
        chk({spi_pin_cfg, th_attention_pin_cfg, smt_attention_pin_cfg}, 12'h111);
        expect_frame('{8'h8a}, 2, 1'b0);
        payload_round(1'b1);
        payload_round(1'b0);
        $display("test forced_spi done");
        boot(1'b0, 1'b1, 1'b1, 4'h1, 4'h0);
        chk(port_sel, `SPSEL_PORT_UART);
        chk(spi_pin_cfg, `SPSEL_PIN_CFG_DISABLED);
        send('{8'h55, 8'h66});
        repeat (10) @(posedge clk);
        chk(n_uart, 2);
        $display("test revert done");
        boot(1'b0, 1'b0, 1'b1, 4'h1, 4'h0);
        pulse_cfg();
        chk({nv_u, nv_s}, 8'h01);
        stored_smt_attention_pin_cfg = `SPSEL_PIN_CFG_DISABLED;
        stored_th_attention_pin_cfg = `SPSEL_PIN_CFG_DISABLED;
        boot(1'b1, 1'b1, 1'b1, nv_u, nv_s);
        chk(port_sel, `SPSEL_PORT_SPI);
        expect_frame('{8'h8a}, 2, 1'b0);
        payload_round(1'b0);
        $display("test stored_spi done");
        boot(1'b1, 1'b1, 1'b0, nv_u, nv_s);
        chk({uart_command_mode, port_sel}, {1'b1, `SPSEL_PORT_UART});
        chk(uart_baud, `SPSEL_UART_BAUD_DEFAULT);
        pulse_cfg();
        chk(nv_u, `SPSEL_PIN_CFG_PERIPH);
        boot(1'b1, 1'b1, 1'b1, nv_u, nv_s);
        chk(uart_enable, 1);
        $display("test recovery done");
        boot(1'b1, 1'b0, 1'b1, 4'h1, 4'h1);
        chk(port_sel, `SPSEL_PORT_UART);
        send('{8'h7e});
        repeat (10) @(posedge clk);
        chk(n_uart, 3);
        spsel_host_i.select(1'b1);
        chk(port_sel, `SPSEL_PORT_SPI);
        pulse_cfg();
        chk(port_sel, `SPSEL_PORT_SPI);
        spsel_host_i.select(1'b0);
        payload_round(1'b0);
        boot(1'b1, 1'b1, 1'b1, 4'h1, 4'h1);
        @(posedge clk);
        #1 uart_rx_seen = 1'b1;
        @(posedge clk);
        #1 uart_rx_seen = 1'b0;
        spsel_host_i.select(1'b1);
        chk(port_sel, `SPSEL_PORT_UART);
        spsel_host_i.select(1'b0);
        $display("test dual done");
        close_out();
    end
endmodule
`default_nettype wire
